/* File: rtl/ivm_cfg.svh */
`ifndef IVM_CFG_SVH
`define IVM_CFG_SVH
// register offsets in data memory
`define IVM_ADDR_GROUP_LEVEL   12'h0e0
`define IVM_ADDR_SINGLE_LEVEL  12'h0e1
`define IVM_ADDR_SW_LOW        12'h0e2
`define IVM_ADDR_SW_HIGH       12'h0e3
`define IVM_ADDR_DIV_TAPS      12'h0e4
`define IVM_ADDR_GROUP_EDGE    12'h0e5
`define IVM_ADDR_SINGLE_EDGE   12'h0e6
`define IVM_ADDR_TUNE_EN       12'h0e7
`define IVM_ADDR_GROUP_EN      12'h0e8
`define IVM_ADDR_SINGLE_EN     12'h0e9
`define IVM_ADDR_LAP_EN        12'h0ea
`define IVM_ADDR_TICK_EN       12'h0eb
`define IVM_ADDR_TUNE_CAUSE    12'h0ec
`define IVM_ADDR_INPUT_CAUSE   12'h0ed
`define IVM_ADDR_LAP_CAUSE     12'h0ee
`define IVM_ADDR_TICK_CAUSE    12'h0ef
`define IVM_ADDR_TUNE_ROM_LOW  12'h0f0
`define IVM_ADDR_MEMREG_LAST   12'h00f
// reset value of every writable register
`define IVM_RESET_NIBBLE       4'h0
// vectors
`define IVM_VEC_TUNE           12'h10a
`define IVM_VEC_SINGLE         12'h108
`define IVM_VEC_GROUP          12'h106
`define IVM_VEC_LAP            12'h104
`define IVM_VEC_TICK           12'h102
// entry sequence: save plus vector load
`define IVM_ENTRY_CYCLES       4'd12
`define IVM_STACK_WORDS        2'd3
`define IVM_PUSH_GAP           4'd4
`endif

/* File: rtl/ivm_pkg.sv */
package ivm_pkg;
	typedef logic [3:0]  ivm_nibble_t;
	typedef logic [11:0] ivm_addr_t;
	typedef enum logic [2:0] {IVM_SRC_NONE, IVM_SRC_TICK, IVM_SRC_LAP, IVM_SRC_GROUP,
		IVM_SRC_SINGLE, IVM_SRC_TUNE} ivm_src_t;
	typedef enum {IVM_IDLE, IVM_WAIT, IVM_ENTRY} ivm_state_t;
endpackage

/* File: rtl/ivm_irq_io.sv */
`timescale 1ns/1ps
`include "ivm_cfg.svh"
// How it works
// - entry waits until the current instruction has fully completed
// - entry pushes the next-instruction address onto the data RAM stack
// - after the save, the vector of the serviced request loads the program counter
// - save plus vector load take exactly twelve clock cycles
// - fixed priority: tune, single input, group inputs, lap timer, tick timer
// - each entry uses three nibbles of stack
// - addresses 000h..00fh are reachable through the memory register pointer
// - cause flags read 1 after the event and clear on being read
// - unimplemented register bits read 0 and ignore writes
// - tune enable is bit 0 of 0e7h, reset masked
// - 0e8h enables the group inputs, bit 0 of 0e9h the single input
// - 0eah: bit 1 enables 1 Hz, bit 0 enables 10 Hz lap events
// - 0ebh: bits 2,1,0 enable 2, 8 and 32 Hz tick events
// - tune cause flag is bit 0 of read-only 0ech
// - 0edh: bit 0 shared group flag, bit 1 single input flag
// - 0efh tick flags 2/8/32 Hz; 0eeh lap flags 1 Hz bit1, 10 Hz bit0
// - edge select bits: 1 falling, 0 rising, reset 0
// - 0e4h returns divider taps 2,4,8,16 Hz on bits 3..0
// - 0f0h holds the low four tune ROM address bits, reset 0
module ivm_irq_io
	import ivm_pkg::*;
(
	input  wire logic              clk,             // system clock
	input  wire logic              srst,            // synchronous reset
	input  wire logic              mem_rd,          // data memory read strobe
	input  wire logic              mem_wr,          // data memory write strobe
	input  wire ivm_pkg::ivm_addr_t mem_addr,        // data memory address
	input  wire ivm_pkg::ivm_nibble_t mem_wdata,     // write data
	output logic [3:0]             mem_rdata,       // read data, registered
	output logic                   mem_hit,         // address decodes to this block
	input  wire logic [3:0]        mem_reg_ptr,     // memory register pointer
	output logic [11:0]            mem_reg_addr,    // address selected by the pointer
	input  wire logic [3:0]        group_inputs,    // four input lines
	input  wire logic              single_input,    // single input line
	input  wire logic [3:0]        stopwatch_low_digit,  // 1/100 s bcd
	input  wire logic [3:0]        stopwatch_high_digit, // 1/10 s bcd
	input  wire logic [3:0]        clock_divider_tap,    // 2/4/8/16 Hz taps
	input  wire logic              tune_event,      // melody event pulse
	input  wire logic [1:0]        lap_event,       // [1]=1 Hz [0]=10 Hz pulses
	input  wire logic [2:0]        tick_event,      // [2]=2 [1]=8 [0]=32 Hz pulses
	input  wire logic              cpu_int_en,      // cpu interrupt flag
	input  wire logic              instr_done,      // current instruction completes
	input  wire logic [11:0]       cpu_pc,          // next instruction address
	output logic                   irq_entry,       // entry sequence running
	output logic                   stack_wr,        // stack nibble write pulse
	output logic [3:0]             stack_wdata,     // pushed nibble
	output logic [1:0]             stack_idx,       // nibble index 0..2
	output logic                   pc_load,         // vector load pulse
	output logic [11:0]            pc_vector,       // vector address
	output logic [3:0]             tune_rom_addr    // low tune rom address
);
	ivm_nibble_t edge_group, tune_en, group_en, tick_en;
	logic        edge_single, single_en;
	logic [1:0]  lap_en, lap_cause;
	logic [2:0]  tick_cause;
	logic        tune_cause, group_cause, single_cause;
	logic [3:0]  group_prev;
	logic        single_prev;
	ivm_state_t  state;
	logic [3:0]  cnt;
	logic [11:0] saved_pc;
	ivm_src_t    src;
	logic [3:0]  group_hit;
	logic        single_hit;
	logic        rd_tune, rd_input, rd_lap, rd_tick;
	logic        req_tune, req_single, req_group, req_lap, req_tick, req_any;

	function automatic logic edge_seen(input logic prev, input logic cur, input logic fall);
		edge_seen = fall ? (prev & ~cur) : (~prev & cur);
	endfunction

	function automatic logic is_read(input logic rd, input ivm_addr_t addr, input ivm_addr_t a);
		is_read = rd && (addr == a);
	endfunction

	// edge detect on the inputs; pins are already synchronous. the previous
	// level follows the pin through reset too, so release shows no false edge
	always_ff @(posedge clk) begin
		group_prev  <= group_inputs;
		single_prev <= single_input;
	end

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			group_hit[i] = edge_seen(group_prev[i], group_inputs[i], edge_group[i]) & group_en[i];
		end
		single_hit = edge_seen(single_prev, single_input, edge_single) & single_en;
	end

	assign rd_tune  = is_read(mem_rd, mem_addr, `IVM_ADDR_TUNE_CAUSE);
	assign rd_input = is_read(mem_rd, mem_addr, `IVM_ADDR_INPUT_CAUSE);
	assign rd_lap   = is_read(mem_rd, mem_addr, `IVM_ADDR_LAP_CAUSE);
	assign rd_tick  = is_read(mem_rd, mem_addr, `IVM_ADDR_TICK_CAUSE);

	// control registers; unimplemented bits are simply not stored
	always_ff @(posedge clk) begin
		if (srst) begin
			edge_group    <= `IVM_RESET_NIBBLE;
			edge_single   <= 1'b0;
			tune_en       <= `IVM_RESET_NIBBLE;
			group_en      <= `IVM_RESET_NIBBLE;
			single_en     <= 1'b0;
			lap_en        <= 2'b00;
			tick_en       <= `IVM_RESET_NIBBLE;
			tune_rom_addr <= `IVM_RESET_NIBBLE;
		end else if (mem_wr) begin
			unique case (mem_addr)
				`IVM_ADDR_GROUP_EDGE:   edge_group    <= mem_wdata;
				`IVM_ADDR_SINGLE_EDGE:  edge_single   <= mem_wdata[0];
				`IVM_ADDR_TUNE_EN:      tune_en       <= {3'b000, mem_wdata[0]};
				`IVM_ADDR_GROUP_EN:     group_en      <= mem_wdata;
				`IVM_ADDR_SINGLE_EN:    single_en     <= mem_wdata[0];
				`IVM_ADDR_LAP_EN:       lap_en        <= mem_wdata[1:0];
				`IVM_ADDR_TICK_EN:      tick_en       <= {1'b0, mem_wdata[2:0]};
				`IVM_ADDR_TUNE_ROM_LOW: tune_rom_addr <= mem_wdata;
				default: ;
			endcase
		end
	end

	// cause flags: a new event in the reading cycle wins over the clear
	always_ff @(posedge clk) begin
		if (srst) begin
			tune_cause   <= 1'b0;
			group_cause  <= 1'b0;
			single_cause <= 1'b0;
			lap_cause    <= 2'b00;
			tick_cause   <= 3'b000;
		end else begin
			tune_cause   <= tune_event | (tune_cause & ~rd_tune);
			group_cause  <= (|group_hit) | (group_cause & ~rd_input);
			single_cause <= single_hit | (single_cause & ~rd_input);
			lap_cause    <= lap_event | (lap_cause & {2{~rd_lap}});
			tick_cause   <= tick_event | (tick_cause & {3{~rd_tick}});
		end
	end

	// read mux; data is captured so it matches the pre-clear flag value
	always_ff @(posedge clk) begin
		if (srst) begin
			mem_rdata <= 4'h0;
		end else if (mem_rd) begin
			unique case (mem_addr)
				`IVM_ADDR_GROUP_LEVEL:   mem_rdata <= group_inputs;
				`IVM_ADDR_SINGLE_LEVEL:  mem_rdata <= {3'b000, single_input};
				`IVM_ADDR_SW_LOW:        mem_rdata <= stopwatch_low_digit;
				`IVM_ADDR_SW_HIGH:       mem_rdata <= stopwatch_high_digit;
				`IVM_ADDR_DIV_TAPS:      mem_rdata <= clock_divider_tap;
				`IVM_ADDR_GROUP_EDGE:    mem_rdata <= edge_group;
				`IVM_ADDR_SINGLE_EDGE:   mem_rdata <= {3'b000, edge_single};
				`IVM_ADDR_TUNE_EN:       mem_rdata <= tune_en;
				`IVM_ADDR_GROUP_EN:      mem_rdata <= group_en;
				`IVM_ADDR_SINGLE_EN:     mem_rdata <= {3'b000, single_en};
				`IVM_ADDR_LAP_EN:        mem_rdata <= {2'b00, lap_en};
				`IVM_ADDR_TICK_EN:       mem_rdata <= tick_en;
				`IVM_ADDR_TUNE_CAUSE:    mem_rdata <= {3'b000, tune_cause};
				`IVM_ADDR_INPUT_CAUSE:   mem_rdata <= {2'b00, single_cause, group_cause};
				`IVM_ADDR_LAP_CAUSE:     mem_rdata <= {2'b00, lap_cause};
				`IVM_ADDR_TICK_CAUSE:    mem_rdata <= {1'b0, tick_cause};
				`IVM_ADDR_TUNE_ROM_LOW:  mem_rdata <= tune_rom_addr;
				default:                 mem_rdata <= 4'h0;
			endcase
		end
	end

	assign mem_hit      = (mem_addr >= `IVM_ADDR_GROUP_LEVEL) && (mem_addr <= `IVM_ADDR_TUNE_ROM_LOW);
	assign mem_reg_addr = {8'h00, mem_reg_ptr};

	// requests gated by flag, enable and the cpu interrupt flag
	assign req_tune   = tune_cause & tune_en[0];
	assign req_single = single_cause & single_en;
	assign req_group  = group_cause;                                    // enable applied at the edge
	assign req_lap    = |(lap_cause & lap_en);
	assign req_tick   = |(tick_cause & tick_en[2:0]);
	assign req_any    = cpu_int_en & (req_tune | req_single | req_group | req_lap | req_tick);

	// entry sequencer: wait for instruction end, then twelve cycles
	always_ff @(posedge clk) begin
		if (srst) begin
			state    <= IVM_IDLE;
			cnt      <= 4'h0;
			saved_pc <= 12'h000;
			src      <= IVM_SRC_NONE;
		end else begin
			unique case (state)
				IVM_IDLE: if (req_any) state <= IVM_WAIT;
				IVM_WAIT: begin
					if (!req_any) begin
						state <= IVM_IDLE;
					end else if (instr_done) begin
						state    <= IVM_ENTRY;
						cnt      <= 4'h0;
						saved_pc <= cpu_pc;
						// priority is sampled at entry start
						if (req_tune)        src <= IVM_SRC_TUNE;
						else if (req_single) src <= IVM_SRC_SINGLE;
						else if (req_group)  src <= IVM_SRC_GROUP;
						else if (req_lap)    src <= IVM_SRC_LAP;
						else                 src <= IVM_SRC_TICK;
					end
				end
				IVM_ENTRY: begin
					if (cnt == `IVM_ENTRY_CYCLES - 4'd1) begin
						state <= IVM_IDLE;
					end
					cnt <= cnt + 4'd1;
				end
			endcase
		end
	end

	// stack pushes every fourth cycle: three nibbles, high first
	always_comb begin
		irq_entry   = (state == IVM_ENTRY);
		stack_wr    = irq_entry && (cnt[1:0] == 2'b00) && (cnt < 4'd12);
		stack_idx   = cnt[3:2];
		unique case (cnt[3:2])
			2'd0:    stack_wdata = saved_pc[11:8];
			2'd1:    stack_wdata = saved_pc[7:4];
			default: stack_wdata = saved_pc[3:0];
		endcase
		pc_load     = irq_entry && (cnt == `IVM_ENTRY_CYCLES - 4'd1);
		unique case (src)
			IVM_SRC_TUNE:   pc_vector = `IVM_VEC_TUNE;
			IVM_SRC_SINGLE: pc_vector = `IVM_VEC_SINGLE;
			IVM_SRC_GROUP:  pc_vector = `IVM_VEC_GROUP;
			IVM_SRC_LAP:    pc_vector = `IVM_VEC_LAP;
			IVM_SRC_TICK:   pc_vector = `IVM_VEC_TICK;
			default:        pc_vector = 12'h000;
		endcase
	end

	// checks; entry_run counts how long the current entry has run, so the
	// twelve-cycle rule needs no long repetition inside a property
	logic [3:0] entry_run;
	logic       entry_take;
	assign entry_take = (state == IVM_WAIT) && req_any && instr_done;
	always_ff @(posedge clk) begin
		if (srst) begin
			entry_run <= 4'h0;
		end else begin
			entry_run <= irq_entry ? entry_run + 4'd1 : 4'h0;
		end
	end

	// entry timing and stack pushes
	entry_start_a: assert property (@(posedge clk) disable iff (srst)
		entry_take |=> irq_entry)
		else $error("entry did not start after instruction end");
	entry_after_a: assert property (@(posedge clk) disable iff (srst)
		$rose(irq_entry) |-> $past(instr_done))
		else $error("entry started inside an instruction");
	entry_len_a: assert property (@(posedge clk) disable iff (srst)
		$fell(irq_entry) |-> entry_run == `IVM_ENTRY_CYCLES)
		else $error("entry length is not twelve cycles");
	entry_max_a: assert property (@(posedge clk) disable iff (srst)
		irq_entry |-> entry_run < `IVM_ENTRY_CYCLES)
		else $error("entry ran past twelve cycles");
	vec_load_a: assert property (@(posedge clk) disable iff (srst)
		$rose(irq_entry) |-> ##11 pc_load)
		else $error("vector not loaded at the last entry cycle");
	push_count_a: assert property (@(posedge clk) disable iff (srst)
		$rose(irq_entry) |-> stack_wr ##4 stack_wr ##4 stack_wr ##4 !stack_wr)
		else $error("entry did not push three nibbles");
	push_idx_a: assert property (@(posedge clk) disable iff (srst)
		$rose(irq_entry) |-> (stack_idx == 2'd0) ##4 (stack_idx == 2'd1) ##4 (stack_idx == 2'd2))
		else $error("stack nibble index out of order");
	push_pc_a: assert property (@(posedge clk) disable iff (srst)
		entry_take |=> stack_wdata == $past(cpu_pc[11:8]))
		else $error("pushed nibble differs from saved address");
	push_rest_a: assert property (@(posedge clk) disable iff (srst)
		$rose(irq_entry) |-> ##4 (stack_wdata == $past(cpu_pc[7:4], 5)) ##4 (stack_wdata == $past(cpu_pc[3:0], 9)))
		else $error("lower pushed nibbles differ from saved address");

	// priority and gating of requests
	tune_prio_a: assert property (@(posedge clk) disable iff (srst)
		(entry_take && req_tune) |=> pc_vector == `IVM_VEC_TUNE)
		else $error("tune request lost priority");
	single_prio_a: assert property (@(posedge clk) disable iff (srst)
		(entry_take && !req_tune && req_single) |=> pc_vector == `IVM_VEC_SINGLE)
		else $error("single input request lost priority");
	group_prio_a: assert property (@(posedge clk) disable iff (srst)
		(entry_take && !req_tune && !req_single && req_group) |=> pc_vector == `IVM_VEC_GROUP)
		else $error("group input request lost priority");
	lap_prio_a: assert property (@(posedge clk) disable iff (srst)
		(entry_take && !req_tune && !req_single && !req_group && req_lap) |=> pc_vector == `IVM_VEC_LAP)
		else $error("lap timer request lost priority");
	tick_prio_a: assert property (@(posedge clk) disable iff (srst)
		(entry_take && !(req_tune || req_single || req_group || req_lap)) |=> pc_vector == `IVM_VEC_TICK)
		else $error("tick request got a wrong vector");
	masked_a: assert property (@(posedge clk) disable iff (srst)
		!cpu_int_en |-> !req_any)
		else $error("request passed with interrupts disabled");
	wait_idle_a: assert property (@(posedge clk) disable iff (srst)
		(state == IVM_WAIT && !req_any) |=> state == IVM_IDLE)
		else $error("withdrawn request still waits");
	tune_mask_a: assert property (@(posedge clk) disable iff (srst)
		!tune_en[0] |-> !req_tune)
		else $error("masked tune request passed");
	single_mask_a: assert property (@(posedge clk) disable iff (srst)
		!single_en |-> !req_single)
		else $error("masked single input request passed");
	lap_mask_a: assert property (@(posedge clk) disable iff (srst)
		(lap_en == 2'b00) |-> !req_lap)
		else $error("masked lap timer request passed");
	tick_mask_a: assert property (@(posedge clk) disable iff (srst)
		(tick_en[2:0] == 3'b000) |-> !req_tick)
		else $error("masked tick request passed");

	// cause flags: set by the event, cleared by a read, set wins
	tune_set_a: assert property (@(posedge clk) disable iff (srst)
		tune_event |=> tune_cause)
		else $error("tune event did not set its flag");
	lap_set_a: assert property (@(posedge clk) disable iff (srst)
		(lap_event != 2'b00) |=> (lap_cause & $past(lap_event)) == $past(lap_event))
		else $error("lap event did not set its flag");
	group_fall_a: assert property (@(posedge clk) disable iff (srst)
		(group_en[0] && edge_group[0] && group_prev[0] && !group_inputs[0]) |=> group_cause)
		else $error("falling group edge not flagged");
	single_rise_a: assert property (@(posedge clk) disable iff (srst)
		(single_en && !edge_single && !single_prev && single_input) |=> single_cause)
		else $error("rising single edge not flagged");
	read_clear_a: assert property (@(posedge clk) disable iff (srst)
		(rd_tune && !tune_event) |=> !tune_cause)
		else $error("cause flag not cleared by read");
	lap_clear_a: assert property (@(posedge clk) disable iff (srst)
		(rd_lap && lap_event == 2'b00) |=> lap_cause == 2'b00)
		else $error("lap flags not cleared by read");
	input_clear_a: assert property (@(posedge clk) disable iff (srst)
		(rd_input && group_hit == 4'h0 && !single_hit) |=> !group_cause && !single_cause)
		else $error("input flags not cleared by read");
	set_wins_a: assert property (@(posedge clk) disable iff (srst)
		(rd_tune && tune_event) |=> tune_cause)
		else $error("event lost against a read clear");

	// register reads and writes
	tune_read_a: assert property (@(posedge clk) disable iff (srst)
		(mem_rd && mem_addr == `IVM_ADDR_TUNE_CAUSE) |=> mem_rdata == {3'b000, $past(tune_cause)})
		else $error("tune flag read wrong");
	input_read_a: assert property (@(posedge clk) disable iff (srst)
		(mem_rd && mem_addr == `IVM_ADDR_INPUT_CAUSE) |=> mem_rdata == {2'b00, $past(single_cause), $past(group_cause)})
		else $error("input flags read wrong");
	tick_read_a: assert property (@(posedge clk) disable iff (srst)
		(mem_rd && mem_addr == `IVM_ADDR_TICK_CAUSE) |=> mem_rdata == {1'b0, $past(tick_cause)})
		else $error("tick flags read wrong");
	taps_read_a: assert property (@(posedge clk) disable iff (srst)
		(mem_rd && mem_addr == `IVM_ADDR_DIV_TAPS) |=> mem_rdata == $past(clock_divider_tap))
		else $error("divider taps read wrong");
	unused_bits_a: assert property (@(posedge clk) disable iff (srst)
		$past(mem_rd && mem_addr == `IVM_ADDR_TICK_CAUSE) |-> mem_rdata[3] == 1'b0)
		else $error("unimplemented bit read as one");
	unmapped_read_a: assert property (@(posedge clk) disable iff (srst)
		(mem_rd && !mem_hit) |=> mem_rdata == 4'h0)
		else $error("unmapped address read nonzero");
	rom_addr_a: assert property (@(posedge clk) disable iff (srst)
		(mem_wr && mem_addr == `IVM_ADDR_TUNE_ROM_LOW) |=> tune_rom_addr == $past(mem_wdata))
		else $error("tune rom address not written");
	tune_en_wr_a: assert property (@(posedge clk) disable iff (srst)
		(mem_wr && mem_addr == `IVM_ADDR_TUNE_EN) |=> tune_en == {3'b000, $past(mem_wdata[0])})
		else $error("tune enable not written");
	group_en_wr_a: assert property (@(posedge clk) disable iff (srst)
		(mem_wr && mem_addr == `IVM_ADDR_GROUP_EN) |=> group_en == $past(mem_wdata))
		else $error("group enables not written");
	lap_en_wr_a: assert property (@(posedge clk) disable iff (srst)
		(mem_wr && mem_addr == `IVM_ADDR_LAP_EN) |=> lap_en == $past(mem_wdata[1:0]))
		else $error("lap enables not written");
	edge_wr_a: assert property (@(posedge clk) disable iff (srst)
		(mem_wr && mem_addr == `IVM_ADDR_GROUP_EDGE) |=> edge_group == $past(mem_wdata))
		else $error("group edge select not written");

	tune_entry_c: cover property (@(posedge clk) disable iff (srst) pc_load && pc_vector == `IVM_VEC_TUNE);
	tick_entry_c: cover property (@(posedge clk) disable iff (srst) pc_load && pc_vector == `IVM_VEC_TICK);
	group_entry_c: cover property (@(posedge clk) disable iff (srst) pc_load && pc_vector == `IVM_VEC_GROUP);
	clear_race_c: cover property (@(posedge clk) disable iff (srst) rd_tune && tune_event);
	wait_drop_c:  cover property (@(posedge clk) disable iff (srst) state == IVM_WAIT && !req_any);
endmodule // ivm_irq_io

/* File: sim/ivm_cpu_model.sv */
`timescale 1ns/1ps
// core stand-in: paces instructions and logs what the entry sequence pushes
module ivm_cpu_model #(
	parameter int GAP = 10              // cycles per instruction
) (
	input  wire logic        clk,         // system clock
	input  wire logic        srst,        // synchronous reset
	input  wire logic        irq_entry,   // entry running
	input  wire logic        stack_wr,    // push strobe
	input  wire logic [3:0]  stack_wdata, // pushed nibble
	input  wire logic [1:0]  stack_idx,   // push index
	output logic             instr_done,  // instruction completes
	output logic [11:0]      cpu_pc,      // next instruction address
	output logic [11:0]      last_pc,     // address handed over last
	output logic [11:0]      pushed,      // pushed nibbles, oldest high
	output logic [1:0]       pcnt,        // pushes in this entry
	output logic             bad_idx      // index out of order
);
	logic [3:0] cnt;
	// the core stalls during entry, so nothing completes then
	always_ff @(posedge clk) begin
		if (srst || irq_entry) begin
			cnt <= 4'h0;
			instr_done <= 1'b0;
		end else begin
			instr_done <= (cnt == 4'(GAP - 1));
			cnt <= (cnt == 4'(GAP - 1)) ? 4'h0 : cnt + 4'h1;
		end
	end
	// odd step changes the low and middle address nibbles at every instruction
	always_ff @(posedge clk) begin
		if (srst) begin
			cpu_pc <= 12'h100;
			last_pc <= 12'h000;
		end else if (instr_done) begin
			last_pc <= cpu_pc;
			cpu_pc <= cpu_pc + 12'h0a7;
		end
	end
	// push log; count restarts once the entry is over
	always_ff @(posedge clk) begin
		if (srst) begin
			pcnt <= 2'd0;
			pushed <= 12'h000;
			bad_idx <= 1'b0;
		end else if (stack_wr) begin
			pushed <= {pushed[7:0], stack_wdata};
			bad_idx <= bad_idx | (stack_idx != pcnt);
			pcnt <= pcnt + 2'd1;
		end else if (!irq_entry) begin
			pcnt <= 2'd0;
		end
	end
endmodule // ivm_cpu_model

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin num_errors++; \
	$display("ERROR t=%0t got %0h exp %0h", $time, (a), (e)); end end
module tb_top;
	import ivm_pkg::*;
	logic        clk, srst, mem_rd, mem_wr, mem_hit, single_input, tune_event, cpu_int_en, seen;
	logic        instr_done, irq_entry, stack_wr, pc_load, bad_idx;
	ivm_addr_t   mem_addr;
	ivm_nibble_t mem_wdata;
	logic [3:0]  mem_rdata, mem_reg_ptr, group_inputs, sw_lo, sw_hi, taps, stack_wdata, tune_rom_addr, d;
	logic [1:0]  lap_event, stack_idx, pcnt;
	logic [2:0]  tick_event;
	logic [11:0] mem_reg_addr, cpu_pc, pc_vector, last_pc, pushed, a;
	int          num_errors, n_compared;
	// address, write nibble, value before the write, value after it
	localparam logic [23:0] ROWS [18] = '{24'h0e0f55, 24'h0e1f00, 24'h0e2f33, 24'h0e3f77, 24'h0e4f99,
		24'h0e5f0f, 24'h0e6f01, 24'h0e7f01, 24'h0e8f0f, 24'h0e9f01, 24'h0eaf03, 24'h0ebf07, 24'h0ecf00,
		24'h0edf00, 24'h0eef00, 24'h0eff00, 24'h0f0a0a, 24'h0d0f00};
	localparam logic [11:0] CA [3] = '{12'h0ec, 12'h0ee, 12'h0ef};
	localparam logic [3:0]  CE [3] = '{4'h1, 4'h3, 4'h7};
	localparam logic [11:0] VEC [4] = '{12'h10a, 12'h108, 12'h104, 12'h102};
	localparam logic [11:0] VCA [4] = '{12'h0ec, 12'h0ed, 12'h0ee, 12'h0ef};

	ivm_irq_io uut (.clk(clk), .srst(srst), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_hit(mem_hit), .mem_reg_ptr(mem_reg_ptr),
		.mem_reg_addr(mem_reg_addr), .group_inputs(group_inputs), .single_input(single_input),
		.stopwatch_low_digit(sw_lo), .stopwatch_high_digit(sw_hi), .clock_divider_tap(taps),
		.tune_event(tune_event), .lap_event(lap_event), .tick_event(tick_event), .cpu_int_en(cpu_int_en),
		.instr_done(instr_done), .cpu_pc(cpu_pc), .irq_entry(irq_entry), .stack_wr(stack_wr),
		.stack_wdata(stack_wdata), .stack_idx(stack_idx), .pc_load(pc_load), .pc_vector(pc_vector),
		.tune_rom_addr(tune_rom_addr));
	ivm_cpu_model cpu (.clk(clk), .srst(srst), .irq_entry(irq_entry), .stack_wr(stack_wr),
		.stack_wdata(stack_wdata), .stack_idx(stack_idx), .instr_done(instr_done), .cpu_pc(cpu_pc),
		.last_pc(last_pc), .pushed(pushed), .pcnt(pcnt), .bad_idx(bad_idx));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// sticky: any entry at all since reset
	always @(posedge clk) seen <= srst ? 1'b0 : (seen | irq_entry);

	task automatic print_verdict;
		if (num_errors == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic wr(input logic [11:0] ad, input logic [3:0] v);
		@(posedge clk) begin mem_wr <= 1'b1; mem_addr <= ad; mem_wdata <= v; end
		@(posedge clk) mem_wr <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] ad, output logic [3:0] v);
		@(posedge clk) begin mem_rd <= 1'b1; mem_addr <= ad; end
		@(posedge clk) mem_rd <= 1'b0;
		#1 v = mem_rdata;
	endtask
	// waits for one entry, checks its timing and pushes, then clears the cause
	task automatic service(input logic [11:0] vec, input logic [11:0] ca);
		int n;
		int k;
		n = 0;
		k = 0;
		while (irq_entry !== 1'b1 && n < 200) begin @(posedge clk); #1 n++; end
		while (irq_entry === 1'b1 && k < 40) begin
			if (pc_load === 1'b1) begin
				`CHK(k, 11)
				`CHK(pc_vector, vec)
				`CHK(pushed, last_pc)
				`CHK(pcnt, 2'd3)
				`CHK(bad_idx, 1'b0)
			end
			@(posedge clk);
			#1 k++;
		end
		`CHK(k, 12)
		rd(ca, d);
	endtask

	// a hang costs a mismatch; the whole run needs far fewer cycles
	initial begin
		#1000000;
		num_errors++;
		print_verdict;
	end
	initial begin
		{srst, mem_rd, mem_wr, mem_addr, mem_wdata, mem_reg_ptr} = {1'b1, 22'h0};
		{group_inputs, single_input, sw_lo, sw_hi, taps} = {4'h5, 1'b0, 4'h3, 4'h7, 4'h9};
		{tune_event, lap_event, tick_event, cpu_int_en} = 7'h0;
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		for (int i = 0; i < 18; i++) begin
			a = ROWS[i][23:12];
			@(posedge clk) mem_reg_ptr <= 4'(i);
			rd(a, d);
			`CHK(d, ROWS[i][7:4])
			`CHK(mem_hit, (a >= 12'h0e0 && a <= 12'h0f0))
			`CHK(mem_reg_addr, {8'h00, 4'(i)})
			wr(a, ROWS[i][11:8]);
			rd(a, d);
			`CHK(d, ROWS[i][3:0])
		end
		`CHK(tune_rom_addr, 4'ha)
		// rising edges are ignored while every line selects falling
		@(posedge clk) begin group_inputs <= 4'hf; single_input <= 1'b1; end
		repeat (3) @(posedge clk);
		rd(12'h0ed, d);
		`CHK(d, 4'h0)
		@(posedge clk) begin group_inputs <= 4'h0; single_input <= 1'b0; end
		repeat (3) @(posedge clk);
		rd(12'h0ed, d);
		`CHK(d, 4'h3)
		rd(12'h0ed, d);
		`CHK(d, 4'h0)
		@(posedge clk) begin tune_event <= 1'b1; lap_event <= 2'b11; tick_event <= 3'b111; end
		@(posedge clk) begin tune_event <= 1'b0; lap_event <= 2'b00; tick_event <= 3'b000; end
		for (int i = 0; i < 3; i++) begin
			rd(CA[i], d);
			`CHK(d, CE[i])
			rd(CA[i], d);
			`CHK(d, 4'h0)
		end
		// an event in the very cycle of the clearing read must survive
		@(posedge clk) begin mem_rd <= 1'b1; mem_addr <= 12'h0ec; tune_event <= 1'b1; end
		@(posedge clk) begin mem_rd <= 1'b0; tune_event <= 1'b0; end
		rd(12'h0ec, d);
		`CHK(d, 4'h1)
		// four sources pending at once, held off by the cpu flag first
		@(posedge clk) begin tune_event <= 1'b1; lap_event <= 2'b01; tick_event <= 3'b001; single_input <= 1'b1; end
		@(posedge clk) begin tune_event <= 1'b0; lap_event <= 2'b00; tick_event <= 3'b000; end
		@(posedge clk) single_input <= 1'b0;
		repeat (60) @(posedge clk);
		`CHK(seen, 1'b0)
		@(posedge clk) cpu_int_en <= 1'b1;
		for (int i = 0; i < 4; i++) service(VEC[i], VCA[i]);
		// group inputs alone: rising edge ignored, falling edge takes its vector
		@(posedge clk) group_inputs <= 4'h2;
		@(posedge clk) group_inputs <= 4'h0;
		service(12'h106, 12'h0ed);
		// second reset in mid-run
		@(posedge clk) srst <= 1'b1;
		@(posedge clk) srst <= 1'b0;
		rd(12'h0e7, d);
		`CHK(d, 4'h0)
		`CHK(tune_rom_addr, 4'h0)
		print_verdict;
	end
endmodule // tb_top
